// ### rtl/can_xcvr_map.svh
// Timing constants and cycle counts for the transceiver mode control
// Notes on behaviour
// - After power-up the transceiver starts in off mode, no driving, no reception.
// - Off mode can be commanded in every chip operating mode.
// - In off mode bus wake-up patterns are ignored, no wake indication.
// - Normal mode only by command and only while the chip is in normal mode.
// - In normal mode the driver is dominant for low transmit input, recessive for high.
// - A low during the enable delay is not sent; only the next dominant bit is.
// - Received bus state is presented as a digital level on the receive output.
// - A receive-only mode lets software observe the bus without transmitting.
// - In wake-capable mode a bus message wakes the system.
// - Wake-capable mode can be selected before the chip goes to sleep.
// - Transmit and receive paths carry bit rates up to 2 Mbaud.
// - The physical layer tolerates flexible-data-rate frames without filtering them.
// - Receive-only keeps driver off, reception on; selectable in chip normal and stop.
// - After a bus wake-up the receive output stays low until the mode changes or the chip enters stop, sleep or failsafe.
// - Wake needs two dominant phases of valid length with a valid recessive between.
// - Transmit dominant beyond time-out forces recessive, sets failure flag, recovers.
`ifndef CAN_XCVR_MAP_SVH
`define CAN_XCVR_MAP_SVH

`define CLK_PERIOD_NS 20
// Enable delay, least time
`define T_CAN_EN_US 200
// Transmit dominant time-out, least time
`define T_TXD_TO_US 4500
// Wake phase bounds: least and longest
`define T_WAKE1_NS 500
`define T_WAKE2_NS 1800

// Least times round up, longest times round down
`define EN_DELAY_CYCLES ((`T_CAN_EN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TXD_TO_CYCLES ((`T_TXD_TO_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MIN_CYCLES ((`T_WAKE1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MAX_CYCLES (`T_WAKE2_NS / `CLK_PERIOD_NS)

// Command buffer depth is fixed at two entries
`define CMD_BUF_DEPTH 2

`endif

// ### rtl/can_xcvr_pkg.sv
// Types shared by the transceiver mode control and its command buffer
package can_xcvr_pkg;

    // Transceiver modes, also the command code
    typedef enum logic [1:0] {
        XM_OFF,
        XM_NORMAL,
        XM_RXONLY,
        XM_WAKE
    } xcvr_mode_e;

    // Operating mode of the surrounding chip
    typedef enum logic [2:0] {
        CM_NORMAL,
        CM_STOP,
        CM_SLEEP,
        CM_RESTART,
        CM_FAILSAFE
    } chip_mode_e;

    // Wake pattern detector progress
    typedef enum logic [1:0] {
        WK_IDLE,
        WK_DOM1,
        WK_REC,
        WK_DOM2
    } wake_state_e;

endpackage

// ### rtl/two_entry_buffer.sv
// Two-entry valid/ready buffer for mode commands
`timescale 1ns/10ps
`include "can_xcvr_map.svh"
module two_entry_buffer #(
    parameter int WIDTH = 2
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    import can_xcvr_pkg::*;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("two_entry_buffer: WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] store [`CMD_BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic [1:0] next_count;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    // Occupancy; flags are registered so the ports come from flops
    assign next_count = count + {1'b0, push} - {1'b0, pop};
    assign out_data_out = store[rd_ptr];

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= 2'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            count <= next_count;
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            in_ready_out <= (next_count != 2'(`CMD_BUF_DEPTH));
            out_valid_out <= (next_count != 2'h0);
        end
    end

    // One write port per entry
    genvar i;
    generate
        for (i = 0; i < `CMD_BUF_DEPTH; i++) begin : g_entry
            always_ff @(posedge clock_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    store[i] <= '0;
                end else if (push && (wr_ptr == 1'(i))) begin
                    store[i] <= in_data_in;
                end
            end
        end
    endgenerate

endmodule

// ### rtl/can_transceiver_mode_ctrl.sv
// Mode control and digital pin behaviour of a CAN FD transceiver
`timescale 1ns/10ps
`include "can_xcvr_map.svh"
module can_transceiver_mode_ctrl #(
    parameter int EN_CYCLES = `EN_DELAY_CYCLES,
    parameter int TXD_TO_CYCLES = `TXD_TO_CYCLES,
    parameter int WAKE_MIN_CYCLES = `WAKE_MIN_CYCLES,
    parameter int WAKE_MAX_CYCLES = `WAKE_MAX_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input can_xcvr_pkg::chip_mode_e chip_mode_in,
    input wire logic cmd_valid_in,
    input can_xcvr_pkg::xcvr_mode_e cmd_mode_in,
    output logic cmd_ready_out,
    input wire logic tx_data_in,
    input wire logic bus_level_in,
    input wire logic fail_clear_in,
    output logic rx_data_out,
    output logic drv_enable_out,
    output logic drv_dominant_out,
    output can_xcvr_pkg::xcvr_mode_e mode_out,
    output logic tx_fail_out,
    output logic wake_out
);
    import can_xcvr_pkg::*;

    localparam int EW = $clog2(EN_CYCLES + 1);
    localparam int TW = $clog2(TXD_TO_CYCLES + 1);
    localparam int WW = $clog2(WAKE_MAX_CYCLES + 1);

    generate
        if (EN_CYCLES < 1 || TXD_TO_CYCLES < 1 || WAKE_MIN_CYCLES < 1 ||
            WAKE_MAX_CYCLES <= WAKE_MIN_CYCLES) begin : g_bad_timing
            $error("can_transceiver_mode_ctrl: timing parameters out of range");
        end
    endgenerate

    // Command path through the two-entry buffer
    logic [$bits(xcvr_mode_e)-1:0] buf_data;
    logic buf_valid;
    wire buf_ready;
    wire xcvr_mode_e buf_cmd = xcvr_mode_e'(buf_data);

    two_entry_buffer #(
        .WIDTH($bits(xcvr_mode_e))
    ) u_cmd_buf (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(cmd_valid_in),
        .in_data_in(cmd_mode_in),
        .in_ready_out(cmd_ready_out),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(buf_ready)
    );

    xcvr_mode_e mode;
    xcvr_mode_e next_mode;
    chip_mode_e chip_prev;
    logic [EW-1:0] en_cnt;
    logic armed;
    logic [TW-1:0] dom_cnt;
    wake_state_e wk_state;
    logic [WW-1:0] ph_cnt;
    logic bus_prev;
    logic woken;

    // Chip mode decode and entry edges
    wire chip_normal = (chip_mode_in == CM_NORMAL);
    wire chip_stop = (chip_mode_in == CM_STOP);
    wire chip_changed = (chip_mode_in != chip_prev);
    wire fs_entry = chip_changed && (chip_mode_in == CM_FAILSAFE);
    wire rearm = chip_changed && (chip_stop || chip_mode_in == CM_SLEEP ||
                                  chip_mode_in == CM_FAILSAFE);

    // Command legality per chip mode
    wire cmd_legal = (buf_cmd == XM_OFF) ||
                     (buf_cmd == XM_WAKE) ||
                     (buf_cmd == XM_NORMAL && chip_normal) ||
                     (buf_cmd == XM_RXONLY && (chip_normal || chip_stop));

    // Commands wait while the enable delay runs; a short stall beats losing one
    wire en_done = (en_cnt == EW'(EN_CYCLES));
    assign buf_ready = !(mode == XM_NORMAL && !en_done);
    wire take = buf_valid && buf_ready;

    // Modes the chip no longer supports fall back to wake-capable
    wire forced = fs_entry ||
                  (mode == XM_NORMAL && !chip_normal) ||
                  (mode == XM_RXONLY && !(chip_normal || chip_stop));
    assign next_mode = forced ? XM_WAKE :
                       (take && cmd_legal) ? buf_cmd : mode;
    wire mode_change = (next_mode != mode);

    // Mode register; off from power-up
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode <= XM_OFF;
            chip_prev <= CM_NORMAL;
        end else begin
            mode <= next_mode;
            chip_prev <= chip_mode_in;
        end
    end

    // Enable delay counter restarts on every mode change
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            en_cnt <= '0;
        end else if (mode_change) begin
            en_cnt <= '0;
        end else if (mode == XM_NORMAL && !en_done) begin
            en_cnt <= en_cnt + EW'(1);
        end
    end

    // Arm only on a high input after the delay; a held-over low is never sent
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            armed <= 1'b0;
        end else if (mode_change || mode != XM_NORMAL) begin
            armed <= 1'b0;
        end else if (en_done && tx_data_in) begin
            armed <= 1'b1;
        end
    end

    // Dominant time-out counter, cleared by any recessive input
    wire to_hit = (dom_cnt == TW'(TXD_TO_CYCLES));
    wire tx_low = armed && !tx_data_in;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dom_cnt <= '0;
        end else if (!tx_low || mode != XM_NORMAL) begin
            dom_cnt <= '0;
        end else if (!to_hit) begin
            dom_cnt <= dom_cnt + TW'(1);
        end
    end

    // Driver path; one flop stage keeps the delay far below a 2 Mbaud bit
    wire next_dominant = (mode == XM_NORMAL) && tx_low && !to_hit;
    wire fail_set = (mode == XM_NORMAL) && tx_low && to_hit;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drv_dominant_out <= 1'b0;
            drv_enable_out <= 1'b0;
            tx_fail_out <= 1'b0;
        end else begin
            drv_dominant_out <= next_dominant;
            drv_enable_out <= (mode == XM_NORMAL);
            tx_fail_out <= fail_set || (tx_fail_out && !fail_clear_in);
        end
    end

    // Wake pattern phase measurement; counter saturates at the long bound
    wire bus_edge = (bus_level_in != bus_prev);
    wire ph_ok = (ph_cnt >= WW'(WAKE_MIN_CYCLES)) && (ph_cnt < WW'(WAKE_MAX_CYCLES));
    wire ph_long = (ph_cnt == WW'(WAKE_MAX_CYCLES));
    wire rec_ok = (ph_cnt > WW'(WAKE_MIN_CYCLES)) && !ph_long;
    wire watching = (mode == XM_WAKE) && !woken && !mode_change;
    wire wake_det = watching && (wk_state == WK_DOM2) && !bus_level_in &&
                    (ph_cnt >= WW'(WAKE_MIN_CYCLES));

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_prev <= 1'b1;
            ph_cnt <= '0;
        end else begin
            bus_prev <= bus_level_in;
            ph_cnt <= bus_edge ? WW'(1) : (ph_long ? ph_cnt : ph_cnt + WW'(1));
        end
    end

    // Two dominant phases with a recessive gap; first dominant in the window, gap in it but not at the least bound, second dominant needs only the least bound
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wk_state <= WK_IDLE;
        end else if (!watching || wake_det) begin
            wk_state <= WK_IDLE;
        end else begin
            unique case (wk_state)
                WK_IDLE: begin
                    if (!bus_level_in && bus_edge) begin
                        wk_state <= WK_DOM1;
                    end
                end
                WK_DOM1: begin
                    if (bus_level_in) begin
                        wk_state <= ph_ok ? WK_REC : WK_IDLE;
                    end
                end
                WK_REC: begin
                    if (!bus_level_in) begin
                        wk_state <= rec_ok ? WK_DOM2 : WK_DOM1;
                    end else if (ph_long) begin
                        wk_state <= WK_IDLE;
                    end
                end
                WK_DOM2: begin
                    if (bus_level_in || ph_long) begin
                        wk_state <= WK_IDLE;
                    end
                end
            endcase
        end
    end

    // Woken flag holds until mode change or chip rearm; detection wins
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            woken <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            woken <= wake_det || (woken && !mode_change && !rearm);
            wake_out <= wake_det;
        end
    end

    // Receive pin: no filtering so short FD bits pass unchanged
    wire next_rx = (mode == XM_OFF) ? 1'b1 :
                   (mode == XM_WAKE) ? !woken : bus_level_in;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_data_out <= 1'b1;
            mode_out <= XM_OFF;
        end else begin
            rx_data_out <= next_rx;
            mode_out <= next_mode;
        end
    end

    // Checks on the behaviour above
    AST_RESET_OFF: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(reset_n_in) |-> (mode == XM_OFF) && !drv_enable_out)
        else $error("Mode not off after reset");

    AST_OFF_ANYTIME: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (take && buf_cmd == XM_OFF && !forced) |=> (mode == XM_OFF))
        else $error("Off command not obeyed");

    AST_OFF_NO_WAKE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (mode == XM_OFF) |=> !wake_out ##0 !woken)
        else $error("Wake reported in off mode");

    AST_NORMAL_ENTRY: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        ($changed(mode) && mode == XM_NORMAL) |->
            $past(chip_mode_in) == CM_NORMAL && $past(take))
        else $error("Normal mode entered without command in chip normal");

    AST_TX_FOLLOW: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (mode == XM_NORMAL && armed && !to_hit) |=> (drv_dominant_out == !$past(tx_data_in)))
        else $error("Driver does not follow transmit input");

    AST_DELAY_MASK: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (mode == XM_NORMAL && !en_done) |=> !drv_dominant_out)
        else $error("Dominant driven during enable delay");

    AST_ARM_HIGH: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(armed) |-> $past(tx_data_in) && $past(en_done))
        else $error("Transmit armed without high input after delay");

    AST_RXONLY: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (mode == XM_RXONLY) |=> !drv_enable_out && !drv_dominant_out &&
            rx_data_out == $past(bus_level_in))
        else $error("Receive-only mode drives or does not receive");

    AST_WAKE_HOLD: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (woken && mode == XM_WAKE) |=> !rx_data_out)
        else $error("Receive output not low after wake");

    AST_WAKE_SRC: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(wake_out) |-> $past(wk_state) == WK_DOM2 &&
            $past(ph_cnt) >= WW'(WAKE_MIN_CYCLES))
        else $error("Wake without full pattern");

    AST_TIMEOUT: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        fail_set |=> !drv_dominant_out && tx_fail_out)
        else $error("Time-out did not force recessive and flag");

    AST_NO_DRIVE_IDLE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (mode != XM_NORMAL) |=> !drv_dominant_out && !drv_enable_out)
        else $error("Driver active outside normal mode");

    AST_WAKE_PULSE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        wake_out |=> !wake_out)
        else $error("Wake pulse longer than one cycle");

    AST_FAIL_STICKY: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (tx_fail_out && !fail_clear_in) |=> tx_fail_out)
        else $error("Failure flag lost without clear");

    COV_WAKE: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(wake_out));
    COV_TIMEOUT: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(tx_fail_out));
    COV_ARMED_TX: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        armed ##1 drv_dominant_out);
    COV_RXONLY: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        $changed(mode) && mode == XM_RXONLY);
    COV_FAILSAFE_WAKE: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        fs_entry ##1 (mode == XM_WAKE));

endmodule

// ### tb/can_ctrl_model.sv
// Behavioural CAN protocol controller driving the transmit pin
`timescale 1ns/10ps
module can_ctrl_model (
    input wire logic clock_in,
    input wire logic start_in,
    input wire logic [15:0] bits_in,
    input wire logic [3:0] bit_cycles_in,
    output logic tx_data_out,
    output logic busy_out
);
    logic [15:0] frame = 16'h0000;
    logic [3:0] bit_idx = 4'h0;
    logic [3:0] hold = 4'h0;

    initial begin
        tx_data_out = 1'b1;
        busy_out = 1'b0;
    end

    // One frame MSB first, each bit held bit_cycles_in clocks; slow rates stretch bits
    always @(posedge clock_in) begin
        if (!busy_out && start_in) begin
            frame <= bits_in;
            busy_out <= 1'b1;
            bit_idx <= 4'hF;
            hold <= 4'h1;
            tx_data_out <= bits_in[15];
        end else if (busy_out && hold < bit_cycles_in) begin
            hold <= hold + 4'h1;
        end else if (busy_out && bit_idx != 4'h0) begin
            bit_idx <= bit_idx - 4'h1;
            hold <= 4'h1;
            tx_data_out <= frame[bit_idx - 4'h1];
        end else begin
            // Idle is recessive, so a low never lingers past a frame
            busy_out <= 1'b0;
            tx_data_out <= 1'b1;
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the transceiver mode control
`timescale 1ns/10ps
module tb_top;
    import can_xcvr_pkg::*;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    chip_mode_e chip_mode_in = CM_NORMAL;
    logic cmd_valid_in = 1'b0;
    xcvr_mode_e cmd_mode_in = XM_OFF;
    logic fail_clear_in = 1'b0;
    logic other_dom = 1'b0;
    logic start = 1'b0;
    logic [15:0] bits = 16'h0000;
    logic [3:0] bit_cyc = 4'h1;
    logic cmd_ready_out, tx_data_in, bus_level_in, rx_data_out, busy;
    logic drv_enable_out, drv_dominant_out, tx_fail_out, wake_out;
    xcvr_mode_e mode_out;
    int n_errors = 0;
    int compares = 0;
    int p;

    always #10 clock_in = ~clock_in;
    // Wired-and bus: any dominant node pulls it low
    assign bus_level_in = ~(drv_dominant_out | other_dom);

    can_transceiver_mode_ctrl #(.EN_CYCLES(8), .TXD_TO_CYCLES(20), .WAKE_MIN_CYCLES(3),
        .WAKE_MAX_CYCLES(10)) i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .chip_mode_in(chip_mode_in), .cmd_valid_in(cmd_valid_in), .cmd_mode_in(cmd_mode_in),
        .cmd_ready_out(cmd_ready_out), .tx_data_in(tx_data_in), .bus_level_in(bus_level_in),
        .fail_clear_in(fail_clear_in), .rx_data_out(rx_data_out),
        .drv_enable_out(drv_enable_out), .drv_dominant_out(drv_dominant_out),
        .mode_out(mode_out), .tx_fail_out(tx_fail_out), .wake_out(wake_out));

    can_ctrl_model i_ctrl (.clock_in(clock_in), .start_in(start), .bits_in(bits),
        .bit_cycles_in(bit_cyc), .tx_data_out(tx_data_in), .busy_out(busy));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock_in);
            #1;
        end
    endtask

    // Hold the command until an edge sees ready high
    task automatic send_cmd(input xcvr_mode_e m);
        int n;
        n = 0;
        step(1);
        cmd_valid_in = 1'b1;
        cmd_mode_in = m;
        while (cmd_ready_out !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        step(1);
        cmd_valid_in = 1'b0;
    endtask

    task automatic wait_mode(input xcvr_mode_e m);
        int n;
        n = 0;
        while (mode_out !== m && n < 40) begin
            step(1);
            n++;
        end
        chk({6'h0, mode_out}, {6'h0, m});
    endtask

    task automatic frame(input logic [15:0] b, input logic [3:0] c);
        bits = b;
        bit_cyc = c;
        start = 1'b1;
        step(1);
        start = 1'b0;
    endtask

    // Driver must mirror the pin one edge later
    task automatic follow_frame(input logic [15:0] b);
        logic t;
        frame(b, 4'h1);
        for (int i = 0; i < 16; i++) begin
            t = tx_data_in;
            step(1);
            chk({7'h0, drv_dominant_out}, {7'h0, ~t});
        end
        step(2);
    endtask

    // Dominant 5, recessive 5, dominant 5 clocks from another node
    task automatic wake_pattern(output int pulses);
        pulses = 0;
        for (int i = 0; i < 25; i++) begin
            other_dom = (i < 5) || (i >= 10 && i < 15);
            step(1);
            if (wake_out === 1'b1) pulses++;
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic t_reset_off();
        chk({6'h0, mode_out}, {6'h0, XM_OFF});
        chk({4'h0, drv_enable_out, drv_dominant_out, rx_data_out, tx_fail_out}, 8'h02);
        wake_pattern(p);
        chk(p[7:0], 8'h00);
        chk({7'h0, rx_data_out}, 8'h01);
        $display("test reset_off done");
    endtask

    task automatic t_enable();
        int seen;
        seen = 0;
        chip_mode_in = CM_STOP;
        send_cmd(XM_NORMAL);
        step(5);
        chk({6'h0, mode_out}, {6'h0, XM_OFF});
        chip_mode_in = CM_NORMAL;
        send_cmd(XM_NORMAL);
        wait_mode(XM_NORMAL);
        // Driver enable follows the registered mode one edge after the mode report
        step(1);
        chk({7'h0, drv_enable_out}, 8'h01);
        // Controller pulls low too early and holds it past the delay
        frame(16'h0000, 4'h1);
        repeat (18) begin
            step(1);
            if (drv_dominant_out !== 1'b0) seen++;
        end
        chk(seen[7:0], 8'h00);
        follow_frame(16'hA35C);
        $display("test enable done");
    endtask

    task automatic t_timeout();
        frame(16'h0000, 4'h2);
        step(5);
        chk({7'h0, drv_dominant_out}, 8'h01);
        // Input still low here, so a recessive driver proves the forcing
        step(20);
        chk({6'h0, drv_dominant_out, tx_fail_out}, 8'h01);
        chk({6'h0, mode_out}, {6'h0, XM_NORMAL});
        step(10);
        follow_frame(16'h5AA5);
        chk({7'h0, tx_fail_out}, 8'h01);
        fail_clear_in = 1'b1;
        step(1);
        fail_clear_in = 1'b0;
        step(1);
        chk({7'h0, tx_fail_out}, 8'h00);
        send_cmd(XM_OFF);
        wait_mode(XM_OFF);
        step(2);
        chk({6'h0, drv_enable_out, rx_data_out}, 8'h01);
        $display("test timeout done");
    endtask

    // Commands pile up while the enable delay stalls the buffer
    task automatic t_buffer();
        send_cmd(XM_NORMAL);
        wait_mode(XM_NORMAL);
        send_cmd(XM_RXONLY);
        send_cmd(XM_OFF);
        chk({7'h0, cmd_ready_out}, 8'h00);
        wait_mode(XM_RXONLY);
        wait_mode(XM_OFF);
        $display("test buffer done");
    endtask

    task automatic t_rxonly();
        chip_mode_in = CM_STOP;
        send_cmd(XM_RXONLY);
        wait_mode(XM_RXONLY);
        frame(16'h0000, 4'h1);
        other_dom = 1'b1;
        step(2);
        chk({6'h0, drv_enable_out, drv_dominant_out}, 8'h00);
        chk({7'h0, rx_data_out}, 8'h00);
        other_dom = 1'b0;
        step(2);
        chk({7'h0, rx_data_out}, 8'h01);
        step(14);
        send_cmd(XM_OFF);
        wait_mode(XM_OFF);
        $display("test rxonly done");
    endtask

    task automatic t_wake();
        chip_mode_in = CM_SLEEP;
        send_cmd(XM_WAKE);
        wait_mode(XM_WAKE);
        wake_pattern(p);
        chk(p[7:0], 8'h01);
        step(10);
        chk({7'h0, rx_data_out}, 8'h00);
        send_cmd(XM_OFF);
        wait_mode(XM_OFF);
        step(2);
        chk({7'h0, rx_data_out}, 8'h01);
        chip_mode_in = CM_FAILSAFE;
        step(3);
        chk({6'h0, mode_out}, {6'h0, XM_WAKE});
        $display("test wake done");
    endtask

    initial begin
        repeat (3) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        t_reset_off();
        t_enable();
        t_timeout();
        t_buffer();
        t_rxonly();
        t_wake();
        results();
    end

    // Whole run needs well under a thousand clocks
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule
